/* File: hdl/swing_lock_pkg.sv */
// Shared constants and types for the clock buffer upper register bank.
// Assumes byte-wide registers reached by an 8-bit offset from the SMBus engine.
package swing_lock_pkg;
   // Register offsets (byte numbers)
   localparam logic [7:0] OFS_SIDEBAND_VIEW_LOW = 8'h0B;
   localparam logic [7:0] OFS_SIDEBAND_VIEW_HIGH = 8'h0C;
   localparam logic [7:0] OFS_OUTPUT_SWING_SETTING = 8'h11;
   localparam logic [7:0] OFS_INPUT_AND_RETENTION_CONFIG = 8'h12;
   localparam logic [7:0] OFS_PERMANENT_WRITE_GUARD = 8'h26;
   localparam logic [7:0] OFS_CLEARABLE_GUARD_AND_LOSS_FLAG = 8'h27;
   // Field positions
   localparam int SWING_MSB = 7;
   localparam int SWING_LSB = 4;
   localparam int AC_SELF_BIAS_BIT = 7;
   localparam int RX_TERM_BIT = 6;
   localparam int KEEP_CONFIG_BIT = 3;
   localparam int LIVE_VIEW_BIT = 0;
   localparam int GUARD_BIT = 0;
   localparam int EVENT_FLAG_BIT = 1;
   // Values after reset
   localparam logic [3:0] SWING_RESET = 4'h7;
   localparam logic AC_SELF_BIAS_RESET = 1'b0;
   localparam logic RX_TERM_RESET = 1'b0;
   localparam logic KEEP_CONFIG_RESET = 1'b1;
   localparam logic [6:0] GUARD_SPARE_RESET = 7'h00;
   localparam logic GUARD_RESET = 1'b0;
   localparam logic EVENT_FLAG_RESET = 1'b0;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // Widths
   localparam int OUTPUT_COUNT = 16;

   // One register access as carried across the clock boundary
   typedef struct packed
   {
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } access_type;
endpackage

/* File: hdl/swing_lock_regs.sv */
// Upper control and status bytes of a clock fanout buffer, with write locks.
// Assumes an SMBus engine on LINK_CLK issuing byte accesses, pins asynchronous.
`timescale 1ns/1ps

// Overview of operation
// - Amplitude nibble sets swing, resets to seven
// - Input byte bits 7/6: self-bias, termination
// - Bit 3 keeps configuration through power down
// - Live bit shows loss detector, low means loss
// - Loss event flag sticky, write one clears
// - Permanent lock blocks control writes until power cycle
module swing_lock_regs
#(
   parameter int OUTPUTS = swing_lock_pkg::OUTPUT_COUNT
)
(
   input wire logic REF_CLK,
   input wire logic NRST,
   input wire logic CE,
   input wire logic LINK_CLK,
   input wire logic REQ,
   input wire swing_lock_pkg::access_type REQ_ACCESS,
   output logic DONE,
   output logic [7:0] RD_DATA,
   input wire logic [OUTPUTS-1:0] SIDEBAND_DISABLE,
   input wire logic SIDEBAND_INTERFACE_ON,
   input wire logic SIGNAL_PRESENT,
   input wire logic POWER_DOWN,
   output logic [3:0] SWING_CODE,
   output logic AC_COUPLED_SELF_BIAS,
   output logic RX_TERM_EN,
   output logic KEEP_CONFIG_IN_POWERDOWN,
   output logic WRITE_BLOCKED,
   output logic SIGNAL_ABSENT_EVENT_FLAG
);
   import swing_lock_pkg::*;

   // Control bytes that the locks protect
   function automatic logic is_control(input logic [7:0] a);
      is_control = (a == OFS_OUTPUT_SWING_SETTING) || (a == OFS_INPUT_AND_RETENTION_CONFIG);
   endfunction

   // Link domain state
   logic link_rst_meta, link_rst_n; // Reset brought into link domain
   access_type held_reg; // Request held across the handshake
   logic req_tgl_reg; // Toggles once per request
   logic busy_reg; // Request outstanding
   logic ack_meta, ack_sync, ack_seen; // Answer toggle synchroniser
   logic done_reg;
   logic [7:0] rd_data_reg;

   // Core domain state
   logic req_meta, req_sync, req_seen; // Request toggle synchroniser
   logic ack_tgl_reg;
   logic [7:0] rd_hold_reg; // Read answer, stable until next request
   logic [OUTPUTS-1:0] sb_meta, sb_sync; // Sideband disable pins
   logic sbon_meta, sbon_sync;
   logic live_meta, live_sync; // Loss detector, high means signal present
   logic pd_meta, pd_sync, pd_seen; // Power down pin
   logic [3:0] swing_reg;
   logic ac_reg, term_reg, keep_reg;
   logic perm_reg; // Permanent lock
   logic [6:0] perm_spare_reg; // Spare writable bits of the permanent byte
   logic clr_lock_reg; // Clearable lock
   logic event_reg; // Sticky loss event
   logic blocked_reg;

   logic do_access, do_wr, locked, pd_fall_cfg, clr_event;
   logic [7:0] rd_next;

   // Reset synchroniser for the link side, no logic on the first stage
   always_ff @(posedge LINK_CLK)
   begin
      link_rst_meta <= NRST;
      link_rst_n <= link_rst_meta;
   end

   // Link side: accept a request when idle, hold it, flip the toggle
   always_ff @(posedge LINK_CLK)
   begin
      if (!link_rst_n)
      begin
         held_reg <= '0;
         req_tgl_reg <= 1'b0;
         busy_reg <= 1'b0;
      end
      else if (REQ && !busy_reg)
      begin
         held_reg <= REQ_ACCESS;
         req_tgl_reg <= ~req_tgl_reg;
         busy_reg <= 1'b1;
      end
      else if (ack_sync != ack_seen)
      begin
         busy_reg <= 1'b0; // Answer arrived
      end
   end

   // Link side: catch the answer toggle and present the read byte
   always_ff @(posedge LINK_CLK)
   begin
      if (!link_rst_n)
      begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
         ack_seen <= 1'b0;
         done_reg <= 1'b0;
         rd_data_reg <= READ_IDLE;
      end
      else
      begin
         ack_meta <= ack_tgl_reg;
         ack_sync <= ack_meta;
         ack_seen <= ack_sync;
         done_reg <= (ack_sync != ack_seen);
         if (ack_sync != ack_seen)
         begin
            rd_data_reg <= rd_hold_reg; // Held stable by the core
         end
      end
   end

   // Core: pin and toggle synchronisers
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         req_meta <= 1'b0;
         req_sync <= 1'b0;
         req_seen <= 1'b0;
         sb_meta <= '0;
         sb_sync <= '0;
         sbon_meta <= 1'b0;
         sbon_sync <= 1'b0;
         live_meta <= 1'b1;
         live_sync <= 1'b1;
         pd_meta <= 1'b0;
         pd_sync <= 1'b0;
         pd_seen <= 1'b0;
      end
      else if (CE)
      begin
         req_meta <= req_tgl_reg;
         req_sync <= req_meta;
         req_seen <= req_sync;
         sb_meta <= SIDEBAND_DISABLE;
         sb_sync <= sb_meta;
         sbon_meta <= SIDEBAND_INTERFACE_ON;
         sbon_sync <= sbon_meta;
         live_meta <= SIGNAL_PRESENT;
         live_sync <= live_meta;
         pd_meta <= POWER_DOWN;
         pd_sync <= pd_meta;
         pd_seen <= pd_sync;
      end
   end

   // Access decode; held_reg is stable while the toggle is in flight
   assign do_access = CE && (req_sync != req_seen);
   assign do_wr = do_access && held_reg.write;
   assign locked = perm_reg || clr_lock_reg;
   assign pd_fall_cfg = CE && pd_sync && !pd_seen && !keep_reg;
   assign clr_event = do_wr && (held_reg.addr == OFS_CLEARABLE_GUARD_AND_LOSS_FLAG) &&
      held_reg.wdata[EVENT_FLAG_BIT];

   // Read multiplexer
   always_comb
   begin
      rd_next = READ_IDLE;
      case (held_reg.addr)
         OFS_SIDEBAND_VIEW_LOW: rd_next = sbon_sync ? sb_sync[7:0] : READ_IDLE;
         OFS_SIDEBAND_VIEW_HIGH: rd_next = sbon_sync ? sb_sync[15:8] : READ_IDLE;
         OFS_OUTPUT_SWING_SETTING: rd_next[SWING_MSB:SWING_LSB] = swing_reg;
         OFS_INPUT_AND_RETENTION_CONFIG:
         begin
            rd_next[AC_SELF_BIAS_BIT] = ac_reg;
            rd_next[RX_TERM_BIT] = term_reg;
            rd_next[KEEP_CONFIG_BIT] = keep_reg;
            rd_next[LIVE_VIEW_BIT] = live_sync;
         end
         OFS_PERMANENT_WRITE_GUARD: rd_next = {perm_spare_reg, perm_reg};
         OFS_CLEARABLE_GUARD_AND_LOSS_FLAG:
         begin
            rd_next[EVENT_FLAG_BIT] = event_reg;
            rd_next[GUARD_BIT] = clr_lock_reg;
         end
         default: rd_next = READ_IDLE; // Unmapped reads as zero
      endcase
   end

   // Core: answer each request once
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         ack_tgl_reg <= 1'b0;
         rd_hold_reg <= READ_IDLE;
      end
      else if (do_access)
      begin
         rd_hold_reg <= held_reg.write ? READ_IDLE : rd_next;
         ack_tgl_reg <= ~ack_tgl_reg;
      end
   end

   // Configuration bytes, guarded by both locks, back to reset values on power down when keep is off
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST || pd_fall_cfg)
      begin
         swing_reg <= SWING_RESET;
         ac_reg <= AC_SELF_BIAS_RESET;
         term_reg <= RX_TERM_RESET;
         keep_reg <= KEEP_CONFIG_RESET;
      end
      else if (do_wr && !locked && is_control(held_reg.addr))
      begin
         if (held_reg.addr == OFS_OUTPUT_SWING_SETTING)
         begin
            swing_reg <= held_reg.wdata[SWING_MSB:SWING_LSB];
         end
         else
         begin
            ac_reg <= held_reg.wdata[AC_SELF_BIAS_BIT];
            term_reg <= held_reg.wdata[RX_TERM_BIT];
            keep_reg <= held_reg.wdata[KEEP_CONFIG_BIT];
         end
      end
   end

   // Permanent lock: set by writing one, only reset clears it
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         perm_reg <= GUARD_RESET;
         perm_spare_reg <= GUARD_SPARE_RESET;
      end
      else if (do_wr && held_reg.addr == OFS_PERMANENT_WRITE_GUARD)
      begin
         perm_reg <= perm_reg | held_reg.wdata[GUARD_BIT];
         perm_spare_reg <= held_reg.wdata[7:1];
      end
   end

   // Clearable lock: a written one sets it when open, clears it when set
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         clr_lock_reg <= GUARD_RESET;
      end
      else if (do_wr && held_reg.addr == OFS_CLEARABLE_GUARD_AND_LOSS_FLAG && held_reg.wdata[GUARD_BIT])
      begin
         clr_lock_reg <= ~clr_lock_reg;
      end
   end

   // Sticky loss event: a present loss wins over a clearing write
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         event_reg <= EVENT_FLAG_RESET;
      end
      else if (CE)
      begin
         event_reg <= !live_sync || (event_reg && !clr_event);
      end
   end

   // Lock summary output
   always_ff @(posedge REF_CLK)
   begin
      if (!NRST)
      begin
         blocked_reg <= 1'b0;
      end
      else if (CE)
      begin
         blocked_reg <= locked;
      end
   end

   assign DONE = done_reg;
   assign RD_DATA = rd_data_reg;
   assign SWING_CODE = swing_reg;
   assign AC_COUPLED_SELF_BIAS = ac_reg;
   assign RX_TERM_EN = term_reg;
   assign KEEP_CONFIG_IN_POWERDOWN = keep_reg;
   assign WRITE_BLOCKED = blocked_reg;
   assign SIGNAL_ABSENT_EVENT_FLAG = event_reg;

   // Checks
   property p_sideband_view;
      @(posedge REF_CLK) disable iff (!NRST)
      do_access && !held_reg.write && held_reg.addr == OFS_SIDEBAND_VIEW_HIGH && sbon_sync
      |=> rd_hold_reg == $past(sb_sync[15:8]);
   endproperty
   a_sideband_view: assert property (p_sideband_view) else $error("sideband view wrong");

   property p_swing_write;
      @(posedge REF_CLK) disable iff (!NRST)
      do_wr && !locked && !pd_fall_cfg && held_reg.addr == OFS_OUTPUT_SWING_SETTING
      |=> swing_reg == $past(held_reg.wdata[7:4]);
   endproperty
   a_swing_write: assert property (p_swing_write) else $error("swing write lost");

   property p_locked_hold;
      @(posedge REF_CLK) disable iff (!NRST)
      do_wr && locked && !pd_fall_cfg |=> $stable(ac_reg) && $stable(term_reg) && $stable(swing_reg);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("locked write changed config");

   property p_pd_clear;
      @(posedge REF_CLK) disable iff (!NRST)
      pd_fall_cfg |=> swing_reg == SWING_RESET && keep_reg && !ac_reg;
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("power down did not clear");

   property p_live_view;
      @(posedge REF_CLK) disable iff (!NRST)
      do_access && !held_reg.write && held_reg.addr == OFS_INPUT_AND_RETENTION_CONFIG
      |=> rd_hold_reg[0] == $past(live_sync);
   endproperty
   a_live_view: assert property (p_live_view) else $error("live view wrong");

   property p_event_set;
      @(posedge REF_CLK) disable iff (!NRST)
      CE && !live_sync |=> event_reg;
   endproperty
   a_event_set: assert property (p_event_set) else $error("loss event missed");

   property p_perm_sticky;
      @(posedge REF_CLK) disable iff (!NRST)
      perm_reg |=> perm_reg ##1 perm_reg;
   endproperty
   a_perm_sticky: assert property (p_perm_sticky) else $error("permanent lock dropped");

   property p_clr_lock;
      @(posedge REF_CLK) disable iff (!NRST)
      clr_lock_reg && do_wr && held_reg.addr == OFS_CLEARABLE_GUARD_AND_LOSS_FLAG && held_reg.wdata[0]
      |=> !clr_lock_reg;
   endproperty
   a_clr_lock: assert property (p_clr_lock) else $error("clearable lock not cleared");

   property p_done_bound;
      @(posedge LINK_CLK) disable iff (!link_rst_n)
      $rose(busy_reg) |-> ##[3:40] done_reg;
   endproperty
   a_done_bound: assert property (p_done_bound) else $error("access never answered");
endmodule

/* File: verif/smbus_host_model.sv */
// SMBus engine stand-in issuing single byte accesses on the link clock.
// Assumes the register bank answers each request with a one-cycle DONE.
`timescale 1ns/1ps
module smbus_host_model
(
   input wire logic LINK_CLK,
   output logic REQ,
   output swing_lock_pkg::access_type REQ_ACCESS,
   input wire logic DONE,
   input wire logic [7:0] RD_DATA
);
   import swing_lock_pkg::*;
   // Answers that never came
   int lost_count;
   // Idle request lines
   initial
   begin
      lost_count = 0;
      REQ = 1'b0;
      REQ_ACCESS = '0;
   end
   // One access: pulse request, hold fields until DONE, then scramble them
   task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                         output logic [7:0] rdata);
      int n;
      n = 0;
      @(posedge LINK_CLK);
      #1;
      REQ = 1'b1;
      REQ_ACCESS = '{write: wr, addr: addr, wdata: wdata};
      @(posedge LINK_CLK);
      #1;
      REQ = 1'b0;
      // Bounded wait for the answer
      while (DONE !== 1'b1 && n < 40)
      begin
         @(posedge LINK_CLK);
         #1;
         n++;
      end
      if (DONE !== 1'b1)
         lost_count++;
      rdata = RD_DATA;
      // Released fields no longer show the last value
      REQ_ACCESS = ~REQ_ACCESS;
   endtask
endmodule

/* File: verif/tb_clock_buffer_status_lock_regs.sv */
// Self-checking bench for the upper register bank with write locks.
// Assumes the host model above stands in for the SMBus engine.
`timescale 1ns/1ps
module tb_clock_buffer_status_lock_regs;
   import swing_lock_pkg::*;
   // Clocks, reset and pins
   logic ref_clk, link_clk, nrst, ce, req, done, sb_on, present, pwr_down;
   logic [15:0] sb_dis;
   access_type req_access;
   logic [7:0] rd_data;
   logic [3:0] swing;
   logic self_bias, term, keep, blocked, ev_flag;
   int err_count = 0;
   int n_compared = 0;
   // Core clock 25 ns
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Link clock 15 ns, shifted phase
   initial
   begin
      link_clk = 1'b0;
      #3;
      forever #7.5 link_clk = ~link_clk;
   end
   swing_lock_regs u_dut (.REF_CLK(ref_clk), .NRST(nrst), .CE(ce), .LINK_CLK(link_clk), .REQ(req),
      .REQ_ACCESS(req_access), .DONE(done), .RD_DATA(rd_data), .SIDEBAND_DISABLE(sb_dis),
      .SIDEBAND_INTERFACE_ON(sb_on), .SIGNAL_PRESENT(present), .POWER_DOWN(pwr_down),
      .SWING_CODE(swing), .AC_COUPLED_SELF_BIAS(self_bias), .RX_TERM_EN(term),
      .KEEP_CONFIG_IN_POWERDOWN(keep), .WRITE_BLOCKED(blocked), .SIGNAL_ABSENT_EVENT_FLAG(ev_flag));
   smbus_host_model u_host (.LINK_CLK(link_clk), .REQ(req), .REQ_ACCESS(req_access), .DONE(done),
      .RD_DATA(rd_data));
   // Compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Register read with comparison
   task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      u_host.access(1'b0, addr, 8'h00, d);
      check(d, exp);
   endtask
   // Register write
   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      logic [7:0] d;
      u_host.access(1'b1, addr, data, d);
   endtask
   // Let pin changes pass the synchronisers
   task automatic settle();
      repeat (4) @(posedge ref_clk);
      #1;
   endtask
   // Verdict
   task automatic close_out();
      if (u_host.lost_count != 0)
         err_count++;
      $display("errors %0d compared %0d", err_count, n_compared);
      if (err_count == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Values after reset
   task automatic s_reset();
      rd(8'h11, 8'h70);
      rd(8'h12, 8'h09);
      check({6'h00, self_bias, term}, 8'h00);
      rd(8'h26, 8'h00);
      rd(8'h27, 8'h00);
      check({7'h00, blocked}, 8'h00);
      check({7'h00, ev_flag}, 8'h00);
      check({4'h0, swing}, 8'h07);
      check({7'h00, keep}, 8'h01);
      rd(8'h20, 8'h00);
   endtask
   // Sideband readback on and off
   task automatic s_sideband();
      sb_dis = 16'hA53C;
      sb_on = 1'b1;
      settle();
      rd(8'h0B, 8'h3C);
      rd(8'h0C, 8'hA5);
      wr(8'h0B, 8'hFF);
      rd(8'h0B, 8'h3C);
      sb_on = 1'b0;
      settle();
      rd(8'h0C, 8'h00);
   endtask
   // Control fields drive outputs
   task automatic s_fields();
      wr(8'h11, 8'hCF);
      rd(8'h11, 8'hC0);
      check({4'h0, swing}, 8'h0C);
      wr(8'h12, 8'hC8);
      rd(8'h12, 8'hC9);
      check({5'h00, self_bias, term, keep}, 8'h07);
   endtask
   // Loss live view and sticky flag
   task automatic s_loss();
      present = 1'b0;
      settle();
      rd(8'h12, 8'hC8);
      wr(8'h27, 8'h02);
      rd(8'h27, 8'h02);
      present = 1'b1;
      settle();
      rd(8'h27, 8'h02);
      check({7'h00, ev_flag}, 8'h01);
      wr(8'h27, 8'h02);
      rd(8'h27, 8'h00);
      check({7'h00, ev_flag}, 8'h00);
      rd(8'h12, 8'hC9);
   endtask
   // Power down clears configuration when keep is off
   task automatic s_power();
      wr(8'h12, 8'hC0);
      check({7'h00, keep}, 8'h00);
      pwr_down = 1'b1;
      settle();
      pwr_down = 1'b0;
      settle();
      rd(8'h12, 8'h09);
      rd(8'h11, 8'h70);
   endtask
   // Clearable lock blocks then releases
   task automatic s_clear_lock();
      wr(8'h27, 8'h01);
      rd(8'h27, 8'h01);
      check({7'h00, blocked}, 8'h01);
      wr(8'h11, 8'h30);
      rd(8'h11, 8'h70);
      wr(8'h27, 8'h01);
      rd(8'h27, 8'h00);
      check({7'h00, blocked}, 8'h00);
      wr(8'h11, 8'h30);
      rd(8'h11, 8'h30);
   endtask
   // Permanent lock sticks until power cycle
   task automatic s_perm_lock();
      wr(8'h26, 8'hA1);
      rd(8'h26, 8'hA1);
      wr(8'h12, 8'hC8);
      rd(8'h12, 8'h09);
      wr(8'h26, 8'h50);
      rd(8'h26, 8'h51);
      check({7'h00, blocked}, 8'h01);
   endtask
   // Clock enable low freezes the core, so a loss goes unseen
   task automatic s_freeze();
      @(posedge ref_clk);
      #1;
      ce = 1'b0;
      present = 1'b0;
      settle();
      check({7'h00, ev_flag}, 8'h00);
      present = 1'b1;
      settle();
      ce = 1'b1;
      settle();
      check({7'h00, ev_flag}, 8'h00);
      rd(8'h27, 8'h00);
   endtask
   // Mid-run reset stands for a power cycle and drops the permanent lock
   task automatic s_power_cycle();
      @(posedge ref_clk);
      #1;
      nrst = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge link_clk);
      rd(8'h26, 8'h00);
      check({7'h00, blocked}, 8'h00);
      wr(8'h11, 8'h50);
      rd(8'h11, 8'h50);
   endtask
   // Main sequence
   initial
   begin
      nrst = 1'b0;
      ce = 1'b1;
      sb_dis = 16'h0000;
      sb_on = 1'b0;
      present = 1'b1;
      pwr_down = 1'b0;
      repeat (5) @(posedge ref_clk);
      #1;
      nrst = 1'b1;
      repeat (4) @(posedge link_clk);
      s_reset();
      s_sideband();
      s_fields();
      s_loss();
      s_freeze();
      s_power();
      s_clear_lock();
      s_perm_lock();
      s_power_cycle();
      close_out();
   end
   // Watchdog
   initial
   begin
      #100us;
      err_count++;
      close_out();
   end
endmodule
